// ==== design/aac_pkg.sv ====
// Shared constants and carriers of the address access control block.
// Assumes a single processor clock domain and an asynchronous active-high reset.
package aac_pkg;
  // Window register field positions
  localparam int BASE_HI = 31;
  localparam int BASE_LO = 24;
  localparam int MASK_HI = 23;
  localparam int MASK_LO = 16;
  localparam int ENABLE_BIT = 15;
  localparam int PRIV_HI = 14;
  localparam int PRIV_LO = 13;
  localparam int USER_HI_BIT = 9;
  localparam int USER_LO_BIT = 8;
  localparam int CACHE_HI = 6;
  localparam int CACHE_LO = 5;
  localparam int WPROT_BIT = 2;
  // Bits that hold state; all others read as zero
  localparam logic [31:0] WINDOW_WRITABLE = 32'hffffe364;
  localparam logic [31:0] WINDOW_RESET = 32'h00000000;
  // Fixed page granularity in bytes
  localparam int PAGE_BYTES = 4096;
  // Window selection on the control register port
  localparam logic [1:0] SEL_FETCH_ZERO = 2'h0;
  localparam logic [1:0] SEL_FETCH_ONE = 2'h1;
  localparam logic [1:0] SEL_OPERAND_ZERO = 2'h2;
  localparam logic [1:0] SEL_OPERAND_ONE = 2'h3;
  // Privilege match field codes
  localparam logic [1:0] PRIV_USER_ONLY = 2'h0;
  localparam logic [1:0] PRIV_SUPER_ONLY = 2'h1;

  typedef enum logic [1:0] {
    AAC_WRITE_THROUGH = 2'h0,
    AAC_COPYBACK = 2'h1,
    AAC_NONCACHE_SERIAL = 2'h2,
    AAC_NONCACHE = 2'h3
  } aac_cache_mode_type;

  // One access presented by a memory unit
  typedef struct packed {
    logic valid;
    logic [31:0] addr;
    logic privilege_code_bit;
    logic write;
    logic rmw;
    logic external;
  } aac_req_type;

  // Answer returned to that memory unit
  typedef struct packed {
    logic valid;
    logic hit;
    logic [31:0] addr;
    aac_cache_mode_type caching_policy_field;
    logic write_protect;
    logic access_error;
    logic user_attr_out_hi;
    logic user_attr_out_lo;
  } aac_rsp_type;
endpackage

// ==== design/aac_checker_unit.sv ====
// One access checker unit with its two window registers' match logic.
// Assumes the window words are supplied by the owning block, already masked.
`timescale 1ns/1ns
module aac_checker_unit (
  // Window configuration
  input wire logic [31:0] window_zero_i,
  input wire logic [31:0] window_one_i,
  // Access
  input wire aac_pkg::aac_req_type req_i,
  // Answer
  output aac_pkg::aac_rsp_type next_rsp_o
);
  logic [1:0] hit;
  logic [31:0] chosen;

  function automatic logic window_match(input logic [31:0] w, input aac_pkg::aac_req_type r);
    logic [7:0] care;
    logic priv_ok;
    care = ~w[aac_pkg::MASK_HI:aac_pkg::MASK_LO];
    unique case (w[aac_pkg::PRIV_HI:aac_pkg::PRIV_LO])
      aac_pkg::PRIV_USER_ONLY: priv_ok = ~r.privilege_code_bit;
      aac_pkg::PRIV_SUPER_ONLY: priv_ok = r.privilege_code_bit;
      default: priv_ok = 1'b1;
    endcase
    // Only A31..A24 take part, so a block is never below 16 Mbytes
    window_match = w[aac_pkg::ENABLE_BIT] & priv_ok &
      (((r.addr[31:24] ^ w[aac_pkg::BASE_HI:aac_pkg::BASE_LO]) & care) == 8'h00);
  endfunction

  always_comb
  begin
    hit[0] = window_match(window_zero_i, req_i);
    hit[1] = window_match(window_one_i, req_i);
    // Window zero wins on overlap
    chosen = hit[0] ? window_zero_i : (hit[1] ? window_one_i : 32'h00000000);
    next_rsp_o.valid = req_i.valid;
    next_rsp_o.hit = req_i.valid & (hit != 2'h0);
    // No translation and no table search
    next_rsp_o.addr = req_i.addr;
    // Unmatched accesses fall back to write-through with no protection
    next_rsp_o.caching_policy_field = aac_pkg::aac_cache_mode_type'(chosen[aac_pkg::CACHE_HI:aac_pkg::CACHE_LO]);
    next_rsp_o.write_protect = chosen[aac_pkg::WPROT_BIT];
    next_rsp_o.access_error = req_i.valid & chosen[aac_pkg::WPROT_BIT] & (req_i.write | req_i.rmw);
    // Echoed only for external transfers, never interpreted
    next_rsp_o.user_attr_out_hi = req_i.valid & req_i.external & chosen[aac_pkg::USER_HI_BIT];
    next_rsp_o.user_attr_out_lo = req_i.valid & req_i.external & chosen[aac_pkg::USER_LO_BIT];
  end
endmodule

// ==== design/aac_address_access_control.sv ====
// Top of the address access control block: four window registers, two checker units.
// Assumes the integer unit drives the control register port from the same clock
// and that access requests come from logic on that clock.
//
// Behaviour
// - Separate fetch and operand checker units.
// - Two 32-bit window registers per unit.
// - Register access only by supervisor move.
// - Blocks at least 16 Mbytes, overlap allowed.
// - Base field compared to address bits 31-24.
// - Mask bits exclude base bits from compare.
// - Enable bit gates a window's matching.
// - Privilege field selects user, supervisor, either.
// - User attribute bits echoed on external transfers.
// - Cache mode field selects access handling.
// - Write protect aborts writes and rmw.
// - Page granularity fixed at 4 Kbytes.
// - Both windows match: window zero wins.
// - No match: address passes unchanged.
// - Protected write abort raises access error.
// - Reset clears all window enable bits.
`timescale 1ns/1ns
module aac_address_access_control (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // Control register move port
  input wire logic creg_wr_i,
  input wire logic creg_rd_i,
  input wire logic creg_supervisor_i,
  input wire logic [1:0] creg_sel_i,
  input wire logic [31:0] creg_wdata_i,
  output logic [31:0] creg_rdata_o,
  output logic creg_rvalid_o,
  output logic creg_priv_error_o,
  // Instruction fetch access
  input wire aac_pkg::aac_req_type fetch_req_i,
  output aac_pkg::aac_rsp_type fetch_rsp_o,
  // Operand access
  input wire aac_pkg::aac_req_type operand_req_i,
  output aac_pkg::aac_rsp_type operand_rsp_o,
  // User attribute pins
  output logic user_attr_out_hi_o,
  output logic user_attr_out_lo_o,
  // Fixed page size shown to the caches
  output logic [12:0] page_bytes_o
);
  logic [31:0] fetch_window_zero;
  logic [31:0] fetch_window_one;
  logic [31:0] operand_window_zero;
  logic [31:0] operand_window_one;
  logic [31:0] next_rdata;
  aac_pkg::aac_rsp_type next_fetch_rsp;
  aac_pkg::aac_rsp_type next_operand_rsp;

  // Reset zeroes every window, which clears each enable bit
  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      fetch_window_zero <= aac_pkg::WINDOW_RESET;
      fetch_window_one <= aac_pkg::WINDOW_RESET;
      operand_window_zero <= aac_pkg::WINDOW_RESET;
      operand_window_one <= aac_pkg::WINDOW_RESET;
    end
    else if (creg_wr_i && creg_supervisor_i)
    begin
      // User-mode writes are dropped
      unique case (creg_sel_i)
        aac_pkg::SEL_FETCH_ZERO: fetch_window_zero <= creg_wdata_i & aac_pkg::WINDOW_WRITABLE;
        aac_pkg::SEL_FETCH_ONE: fetch_window_one <= creg_wdata_i & aac_pkg::WINDOW_WRITABLE;
        aac_pkg::SEL_OPERAND_ZERO: operand_window_zero <= creg_wdata_i & aac_pkg::WINDOW_WRITABLE;
        aac_pkg::SEL_OPERAND_ONE: operand_window_one <= creg_wdata_i & aac_pkg::WINDOW_WRITABLE;
      endcase
    end
  end

  always_comb
  begin
    unique case (creg_sel_i)
      aac_pkg::SEL_FETCH_ZERO: next_rdata = fetch_window_zero;
      aac_pkg::SEL_FETCH_ONE: next_rdata = fetch_window_one;
      aac_pkg::SEL_OPERAND_ZERO: next_rdata = operand_window_zero;
      aac_pkg::SEL_OPERAND_ONE: next_rdata = operand_window_one;
    endcase
  end

  // Read data answers one cycle after the request; user reads return zero
  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      creg_rdata_o <= 32'h00000000;
      creg_rvalid_o <= 1'b0;
      creg_priv_error_o <= 1'b0;
    end
    else
    begin
      creg_rvalid_o <= creg_rd_i;
      creg_rdata_o <= (creg_rd_i && creg_supervisor_i) ? next_rdata : 32'h00000000;
      creg_priv_error_o <= (creg_rd_i | creg_wr_i) & ~creg_supervisor_i;
    end
  end

  // Independent units keep fetch and operand spaces apart
  aac_checker_unit u_fetch (
    .window_zero_i(fetch_window_zero),
    .window_one_i(fetch_window_one),
    .req_i(fetch_req_i),
    .next_rsp_o(next_fetch_rsp)
  );

  aac_checker_unit u_operand (
    .window_zero_i(operand_window_zero),
    .window_one_i(operand_window_one),
    .req_i(operand_req_i),
    .next_rsp_o(next_operand_rsp)
  );

  // Match is evaluated in the cycle the access is presented and registered at its end
  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      fetch_rsp_o <= '0;
      operand_rsp_o <= '0;
    end
    else
    begin
      fetch_rsp_o <= next_fetch_rsp;
      operand_rsp_o <= next_operand_rsp;
    end
  end

  // One set of pins: an operand transfer takes precedence over a fetch in the same cycle
  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      user_attr_out_hi_o <= 1'b0;
      user_attr_out_lo_o <= 1'b0;
    end
    else if (operand_req_i.valid && operand_req_i.external)
    begin
      user_attr_out_hi_o <= next_operand_rsp.user_attr_out_hi;
      user_attr_out_lo_o <= next_operand_rsp.user_attr_out_lo;
    end
    else
    begin
      user_attr_out_hi_o <= next_fetch_rsp.user_attr_out_hi;
      user_attr_out_lo_o <= next_fetch_rsp.user_attr_out_lo;
    end
  end

  // No page size selection exists
  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
      page_bytes_o <= 13'(aac_pkg::PAGE_BYTES);
    else
      page_bytes_o <= 13'(aac_pkg::PAGE_BYTES);
  end
endmodule

// ==== bench/aac_assertions.sv ====
// Port-level checks for the address access control top.
// Assumes one clock domain; bound to every instance of the top.
`timescale 1ns/1ns
module aac_assertions (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // Control register port
  input wire logic creg_wr_i,
  input wire logic creg_rd_i,
  input wire logic creg_supervisor_i,
  input wire logic [31:0] creg_rdata_o,
  input wire logic creg_rvalid_o,
  input wire logic creg_priv_error_o,
  // Access ports
  input wire aac_pkg::aac_req_type fetch_req_i,
  input wire aac_pkg::aac_rsp_type fetch_rsp_o,
  input wire aac_pkg::aac_req_type operand_req_i,
  input wire aac_pkg::aac_rsp_type operand_rsp_o,
  // Page size
  input wire logic [12:0] page_bytes_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  read_answer_a: assert property (creg_rd_i |=> creg_rvalid_o)
    else $error("read not answered");
  user_refused_a: assert property ((creg_rd_i || creg_wr_i) && !creg_supervisor_i |=> creg_priv_error_o)
    else $error("user register access not flagged");
  user_read_a: assert property (creg_rd_i && !creg_supervisor_i |=> creg_rdata_o == 32'h0)
    else $error("user read returned data");
  zero_bits_a: assert property (creg_rvalid_o |-> (creg_rdata_o & 32'h00001c9b) == 32'h0)
    else $error("fixed bits read nonzero");
  fetch_answer_a: assert property (fetch_req_i.valid |=> fetch_rsp_o.valid && fetch_rsp_o.addr == $past(fetch_req_i.addr))
    else $error("fetch answer wrong");
  operand_answer_a: assert property (operand_req_i.valid |=> operand_rsp_o.valid && operand_rsp_o.addr == $past(operand_req_i.addr))
    else $error("operand answer wrong");
  idle_quiet_a: assert property (!fetch_req_i.valid |=> !fetch_rsp_o.valid)
    else $error("answer without access");
  operand_idle_a: assert property (!operand_req_i.valid |=> !operand_rsp_o.valid)
    else $error("operand answer without access");
  miss_plain_a: assert property (operand_rsp_o.valid && !operand_rsp_o.hit |-> operand_rsp_o.caching_policy_field == aac_pkg::AAC_WRITE_THROUGH && !operand_rsp_o.access_error)
    else $error("miss carries attributes");
  error_cause_a: assert property (operand_rsp_o.access_error |-> operand_rsp_o.hit && operand_rsp_o.write_protect)
    else $error("error without protected hit");
  page_fixed_a: assert property (page_bytes_o == 13'h1000)
    else $error("page size not fixed");
endmodule

bind aac_address_access_control aac_assertions chk_i (.*);

// ==== bench/aac_mem_model.sv ====
// Memory unit model that presents one access at a time to a checker unit.
// Assumes the same clock as the design; drives just after the rising edge.
`timescale 1ns/1ns
module aac_mem_model (
  // Clock
  input wire logic sys_clk_i,
  // Access request
  output aac_pkg::aac_req_type req_o
);
  initial req_o = '0;
  // Idle address shows a flipped pattern so a stale value never looks valid
  task automatic access(input logic [31:0] addr, input logic sup, input logic wr, input logic rmw = 1'b0);
    @(posedge sys_clk_i);
    #1 req_o = {1'b1, addr, sup, wr, rmw, 1'b1};
    @(posedge sys_clk_i);
    #1 req_o = {1'b0, ~addr, 4'h0};
  endtask
endmodule

// ==== bench/tb_aac_address_access_control.sv ====
// Self-checking bench of the address access control top.
// Assumes the design sources and the checker are compiled first.
`timescale 1ns/1ns
module tb_aac_address_access_control;
  logic sys_clk_i = 0, rst_i = 1, creg_wr_i = 0, creg_rd_i = 0, creg_supervisor_i = 0;
  logic [1:0] creg_sel_i = 2'h0;
  logic [31:0] creg_wdata_i = 32'h0, creg_rdata_o;
  logic creg_rvalid_o, creg_priv_error_o, user_attr_out_hi_o, user_attr_out_lo_o;
  logic [12:0] page_bytes_o;
  aac_pkg::aac_req_type fetch_req_i, operand_req_i;
  aac_pkg::aac_rsp_type fetch_rsp_o, operand_rsp_o;
  int fails = 0, checked = 0;
  aac_mem_model fmem (.sys_clk_i(sys_clk_i), .req_o(fetch_req_i));
  aac_mem_model omem (.sys_clk_i(sys_clk_i), .req_o(operand_req_i));
  aac_address_access_control dut (.*);
  initial forever #2 sys_clk_i = ~sys_clk_i;
  task automatic complete_run;
    if (fails == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp)
    begin
      fails++;
      $display("unexpected %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wr(input logic [1:0] sel, input logic [31:0] data, input logic sup);
    @(posedge sys_clk_i);
    #1 {creg_wr_i, creg_sel_i, creg_wdata_i, creg_supervisor_i} = {1'b1, sel, data, sup};
    @(posedge sys_clk_i);
    #1 creg_wr_i = 0;
    chk("wr_error", {31'h0, !sup}, {31'h0, creg_priv_error_o});
  endtask
  task automatic rd(input logic [1:0] sel, input logic sup, input logic [31:0] exp);
    @(posedge sys_clk_i);
    #1 {creg_rd_i, creg_sel_i, creg_supervisor_i} = {1'b1, sel, sup};
    @(posedge sys_clk_i);
    #1 creg_rd_i = 0;
    chk("rvalid", 32'h1, {31'h0, creg_rvalid_o});
    chk("rd_error", {31'h0, !sup}, {31'h0, creg_priv_error_o});
    chk("rdata", exp, creg_rdata_o);
  endtask
  task automatic acc(input logic op, input logic [31:0] addr, input logic sup, input logic w,
    input logic hit, input logic [1:0] cm, input logic err, input logic [1:0] ua, input logic rmw = 1'b0);
    aac_pkg::aac_rsp_type r;
    if (op)
      omem.access(addr, sup, w, rmw);
    else
      fmem.access(addr, sup, w, rmw);
    r = op ? operand_rsp_o : fetch_rsp_o;
    chk("rsp_valid", 32'h1, {31'h0, r.valid});
    chk("hit", {31'h0, hit}, {31'h0, r.hit});
    chk("addr", addr, r.addr);
    chk("cache_mode", {30'h0, cm}, {30'h0, r.caching_policy_field});
    chk("access_error", {31'h0, err}, {31'h0, r.access_error});
    chk("user_pins", {30'h0, ua}, {30'h0, user_attr_out_hi_o, user_attr_out_lo_o});
  endtask
  initial
  begin
    repeat (8) @(posedge sys_clk_i);
    #1 rst_i = 0;
    for (int i = 0; i < 4; i++)
      rd(i[1:0], 1, 32'h0);
    wr(2'h0, 32'hffffffff, 1);
    rd(2'h0, 1, 32'hffffe364);
    wr(2'h1, 32'h12008000, 0);
    rd(2'h1, 0, 32'h0);
    rd(2'h1, 1, 32'h0);
    wr(2'h0, 32'h1200a240, 1);
    acc(0, 32'h12345678, 1, 0, 1, 2'h2, 0, 2'h2);
    acc(0, 32'h12345678, 0, 0, 0, 2'h0, 0, 2'h0);
    acc(0, 32'h13000000, 1, 0, 0, 2'h0, 0, 2'h0);
    wr(2'h1, 32'h1300c000, 1);
    acc(0, 32'h13000000, 0, 1, 1, 2'h0, 0, 2'h0);
    acc(1, 32'h13000000, 0, 1, 0, 2'h0, 0, 2'h0);
    wr(2'h2, 32'h200fc124, 1);
    wr(2'h3, 32'h2000c060, 1);
    acc(1, 32'h2a000000, 0, 1, 1, 2'h1, 1, 2'h1);
    acc(1, 32'h2a000000, 0, 0, 1, 2'h1, 1, 2'h1, 1);
    acc(1, 32'h20000000, 1, 0, 1, 2'h1, 0, 2'h1);
    acc(1, 32'h30000000, 1, 0, 0, 2'h0, 0, 2'h0);
    wr(2'h0, 32'h12002240, 1);
    acc(0, 32'h12345678, 1, 0, 0, 2'h0, 0, 2'h0);
    chk("page_bytes", 32'h1000, {19'h0, page_bytes_o});
    #1 rst_i = 1;
    @(posedge sys_clk_i);
    #1 rst_i = 0;
    rd(2'h2, 1, 32'h0);
    complete_run();
  end
  // Run needs well under 1000 cycles
  initial
  begin
    #20000;
    fails++;
    complete_run();
  end
endmodule
